// >>> inc/stp_pkg.sv
`default_nettype none
package stp_pkg;

	// Port state sequence, stepped by the mode select input
	typedef enum logic [3:0] {
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} stp_tap_state_e;

	// Instruction register
	localparam int          IR_WIDTH    = 4;
	localparam logic [3:0]  IR_CAPTURE  = 4'h1;
	localparam logic [3:0]  IR_IDCODE   = 4'h1;
	localparam logic [3:0]  IR_EMUCTRL  = 4'h2;
	localparam logic [3:0]  IR_BYPASS   = 4'hf;

	// Data registers
	localparam int          DR_WIDTH    = 32;
	localparam logic [31:0] ID_VALUE    = 32'h00000001; // Arbitrary value, bit 0 set as the scan standard asks
	localparam int          EMU_WIDTH   = 4;
	localparam logic [3:0]  EMU_RESET   = 4'h0;
	localparam int          EMU_A_DIR   = 0;
	localparam int          EMU_A_VAL   = 1;
	localparam int          EMU_B_DIR   = 2;
	localparam int          EMU_B_VAL   = 3;

endpackage
`default_nettype wire

// >>> inc/stp_tap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stp_tap_if;
	import stp_pkg::*;

	stp_tap_state_e tapState;
	logic           inReset;
	logic           captureDr;
	logic           shiftDr;
	logic           updateDr;
	logic           captureIr;
	logic           shiftIr;
	logic           updateIr;

	modport fsm (
		output tapState, inReset, captureDr, shiftDr, updateDr, captureIr, shiftIr, updateIr
	);
	modport user (
		input  tapState, inReset, captureDr, shiftDr, updateDr, captureIr, shiftIr, updateIr
	);
endinterface
`default_nettype wire

// >>> rtl/stp_scan_port.sv
// Functional notes
// - Mode select and data sampled on rising edge
// - Data output changes only on falling edge
// - Data output floats unless a scan shifts
// - Output-disable low also floats data output
// - Scan reset high gives scan system control
// - Scan reset low: functional, scan pins ignored
// - Emulator pin A interrupt, direction set by scan
// - Emulator pin B interrupt, direction set by scan
// - Scan reset low: pin B is output-disable
// - Output-disable active floats every output driver
// - Host ready output floats under output-disable
`timescale 1ns/1ps
`default_nettype none
module stp_scan_port
	import stp_pkg::*;
(
	// Core clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// Scan link
	input  wire logic testClock,
	input  wire logic scanReset,
	input  wire logic modeSelect,
	input  wire logic testDataIn,
	output logic      testDataOut,
	output logic      testDataOutOe,
	// Emulator event pin A
	input  wire logic emulatorEventPinAIn,
	output logic      emulatorEventPinAOut,
	output logic      emulatorEventPinAOe,
	// Emulator event pin B, output-disable in functional mode
	input  wire logic emulatorEventBOrOutputDisableIn,
	output logic      emulatorEventBOrOutputDisableOut,
	output logic      emulatorEventBOrOutputDisableOe,
	// Core side
	input  wire logic coreEventA,
	input  wire logic coreEventB,
	output logic      emuIrqA,
	output logic      emuIrqB,
	output logic      scanControl,
	output logic      outputsDisabled,
	// Host port ready
	input  wire logic hostReadyIn,
	output logic      hostPortReadyOut,
	output logic      hostPortReadyOutOe
);

	stp_tap_if tap ();

	// Port state machine on the link clock
	stp_tap_fsm u_fsm (
		.testClock  (testClock),
		.scanReset  (scanReset),
		.modeSelect (modeSelect),
		.tap        (tap)
	);

	// Shift length of the selected data register
	function automatic int drLength(input logic [IR_WIDTH-1:0] instr);
		case (instr)
			IR_IDCODE:  drLength = DR_WIDTH;
			IR_EMUCTRL: drLength = EMU_WIDTH;
			default:    drLength = 1;
		endcase
	endfunction

	// Link clock domain
	logic [IR_WIDTH-1:0]  ir_reg,      ir_next;
	logic [IR_WIDTH-1:0]  irShift_reg, irShift_next;
	logic [DR_WIDTH-1:0]  drShift_reg, drShift_next;
	logic [EMU_WIDTH-1:0] emuCtrl_reg, emuCtrl_next;
	logic [1:0]           pinASync_reg, pinBSync_reg;
	logic [1:0]           offTck_reg;
	logic                 tdo_reg,     tdo_next;
	logic                 tdoAct_reg,  tdoAct_next;

	// Instruction and data register paths
	always_comb begin
		ir_next      = ir_reg;
		irShift_next = irShift_reg;
		drShift_next = drShift_reg;
		emuCtrl_next = emuCtrl_reg;
		if (tap.inReset) begin
			ir_next      = IR_IDCODE;
			emuCtrl_next = EMU_RESET;
		end
		if (tap.captureIr) begin
			irShift_next = IR_CAPTURE;
		end else if (tap.shiftIr) begin
			irShift_next = {testDataIn, irShift_reg[IR_WIDTH-1:1]};
		end
		if (tap.updateIr) begin
			ir_next = irShift_reg;
		end
		if (tap.captureDr) begin
			case (ir_reg)
				IR_IDCODE:  drShift_next = ID_VALUE;
				IR_EMUCTRL: drShift_next = {{(DR_WIDTH-EMU_WIDTH){1'b0}}, pinBSync_reg[1], emuCtrl_reg[EMU_B_DIR],
				                           pinASync_reg[1], emuCtrl_reg[EMU_A_DIR]};
				default:    drShift_next = '0;
			endcase
		end else if (tap.shiftDr) begin
			drShift_next = drShift_reg >> 1;
			drShift_next[drLength(ir_reg)-1] = testDataIn;
		end
		if (tap.updateDr && ir_reg == IR_EMUCTRL) begin
			emuCtrl_next = drShift_reg[EMU_WIDTH-1:0];
		end
	end

	// Rising edge registers; scan reset low ignores the scan pins
	always_ff @(posedge testClock) begin
		if (!scanReset) begin
			ir_reg      <= IR_IDCODE;
			irShift_reg <= '0;
			drShift_reg <= '0;
			emuCtrl_reg <= EMU_RESET;
		end else begin
			ir_reg      <= ir_next;
			irShift_reg <= irShift_next;
			drShift_reg <= drShift_next;
			emuCtrl_reg <= emuCtrl_next;
		end
	end

	// Pin and core levels brought onto the link clock
	always_ff @(posedge testClock) begin
		pinASync_reg  <= {pinASync_reg[0], emulatorEventPinAIn};
		pinBSync_reg  <= {pinBSync_reg[0], emulatorEventBOrOutputDisableIn};
		offTck_reg    <= {offTck_reg[0], outputsDisabled};
	end

	// Output bit and scan activity for the falling edge
	always_comb begin
		tdoAct_next = scanReset && (tap.shiftDr || tap.shiftIr);
		tdo_next    = tap.shiftIr ? irShift_reg[0] : drShift_reg[0];
	end

	// Data output changes on the falling edge only
	always_ff @(negedge testClock) begin
		if (!scanReset) begin
			tdo_reg    <= 1'b0;
			tdoAct_reg <= 1'b0;
		end else begin
			tdo_reg    <= tdo_next;
			tdoAct_reg <= tdoAct_next;
		end
	end

	// Data output driver
	assign testDataOut   = tdo_reg;
	assign testDataOutOe = tdoAct_reg && !offTck_reg[1];

	// Core clock domain
	logic [1:0] trstSync_reg, pinAM_reg, pinBM_reg;
	logic       off_reg,   off_next;
	logic       scan_reg,  scan_next;
	logic       irqA_reg,  irqA_next;
	logic       irqB_reg,  irqB_next;
	logic       ready_reg, ready_next;
	logic       coreA_reg, coreA_next;
	logic       coreB_reg, coreB_next;

	// Two-stage synchronisers for the pins
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			trstSync_reg <= 2'h0;
			pinAM_reg    <= 2'h3;
			pinBM_reg    <= 2'h3;
		end else begin
			trstSync_reg <= {trstSync_reg[0], scanReset};
			pinAM_reg    <= {pinAM_reg[0], emulatorEventPinAIn};
			pinBM_reg    <= {pinBM_reg[0], emulatorEventBOrOutputDisableIn};
		end
	end

	// Mode, output-disable and emulator interrupts
	always_comb begin
		scan_next  = trstSync_reg[1];
		off_next   = !trstSync_reg[1] && pinAM_reg[1] && !pinBM_reg[1];
		irqA_next  = trstSync_reg[1] && !pinAM_reg[1];
		irqB_next  = trstSync_reg[1] && !pinBM_reg[1];
		ready_next = hostReadyIn;
		coreA_next = coreEventA;
		coreB_next = coreEventB;
	end

	// Core-side registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			scan_reg  <= 1'b0;
			off_reg   <= 1'b0;
			irqA_reg  <= 1'b0;
			irqB_reg  <= 1'b0;
			ready_reg <= 1'b0;
			coreA_reg <= 1'b0;
			coreB_reg <= 1'b0;
		end else begin
			scan_reg  <= scan_next;
			off_reg   <= off_next;
			irqA_reg  <= irqA_next;
			irqB_reg  <= irqB_next;
			ready_reg <= ready_next;
			coreA_reg <= coreA_next;
			coreB_reg <= coreB_next;
		end
	end

	// Core-side outputs
	assign scanControl        = scan_reg;
	assign outputsDisabled    = off_reg;
	assign emuIrqA            = irqA_reg;
	assign emuIrqB            = irqB_reg;
	assign hostPortReadyOut   = ready_reg;
	assign hostPortReadyOutOe = !off_reg;

	// Emulator pin drivers; core levels ride the core clock so they reach the pins while the link clock is parked
	assign emulatorEventPinAOut = emuCtrl_reg[EMU_A_VAL] || coreA_reg;
	assign emulatorEventPinAOe  = scanReset && emuCtrl_reg[EMU_A_DIR] && !offTck_reg[1];
	assign emulatorEventBOrOutputDisableOut = emuCtrl_reg[EMU_B_VAL] || coreB_reg;
	assign emulatorEventBOrOutputDisableOe  = scanReset && emuCtrl_reg[EMU_B_DIR]
	                                          && !offTck_reg[1];

endmodule
`default_nettype wire

// >>> rtl/stp_tap_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module stp_tap_fsm
	import stp_pkg::*;
(
	// Scan link
	input  wire logic testClock,
	input  wire logic scanReset,
	input  wire logic modeSelect,
	// Decoded state
	stp_tap_if.fsm    tap
);

	stp_tap_state_e state_reg;
	stp_tap_state_e state_next;

	// Next state from mode select
	always_comb begin
		case (state_reg)
			TAP_RESET:    state_next = modeSelect ? TAP_RESET    : TAP_IDLE;
			TAP_IDLE:     state_next = modeSelect ? TAP_SEL_DR   : TAP_IDLE;
			TAP_SEL_DR:   state_next = modeSelect ? TAP_SEL_IR   : TAP_CAP_DR;
			TAP_CAP_DR:   state_next = modeSelect ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: state_next = modeSelect ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: state_next = modeSelect ? TAP_UPD_DR   : TAP_PAUSE_DR;
			TAP_PAUSE_DR: state_next = modeSelect ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: state_next = modeSelect ? TAP_UPD_DR   : TAP_SHIFT_DR;
			TAP_UPD_DR:   state_next = modeSelect ? TAP_SEL_DR   : TAP_IDLE;
			TAP_SEL_IR:   state_next = modeSelect ? TAP_RESET    : TAP_CAP_IR;
			TAP_CAP_IR:   state_next = modeSelect ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: state_next = modeSelect ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: state_next = modeSelect ? TAP_UPD_IR   : TAP_PAUSE_IR;
			TAP_PAUSE_IR: state_next = modeSelect ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: state_next = modeSelect ? TAP_UPD_IR   : TAP_SHIFT_IR;
			TAP_UPD_IR:   state_next = modeSelect ? TAP_SEL_DR   : TAP_IDLE;
			default:      state_next = TAP_RESET;
		endcase
	end

	// Rising edge sampling; scan reset low holds the port in reset
	always_ff @(posedge testClock) begin
		if (!scanReset) begin
			state_reg <= TAP_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// State decodes for the register paths
	assign tap.tapState  = state_reg;
	assign tap.inReset   = (state_reg == TAP_RESET);
	assign tap.captureDr = (state_reg == TAP_CAP_DR);
	assign tap.shiftDr   = (state_reg == TAP_SHIFT_DR);
	assign tap.updateDr  = (state_reg == TAP_UPD_DR);
	assign tap.captureIr = (state_reg == TAP_CAP_IR);
	assign tap.shiftIr   = (state_reg == TAP_SHIFT_IR);
	assign tap.updateIr  = (state_reg == TAP_UPD_IR);

endmodule
`default_nettype wire

// >>> verif/stp_emu_model.sv
`timescale 1ns/1ps
`default_nettype none
module stp_emu_model (
	// Link towards the port
	output logic      testClock,
	output logic      modeSelect,
	output logic      testDataIn,
	input  wire logic testDataOut,
	input  wire logic testDataOutOe,
	// Emulator pins, pulled low while set
	output logic      pinALow,
	output logic      pinBLow
);
	logic [63:0] tdoSeen;
	logic [63:0] oeSeen;
	// Idle: clock parked low, pulled-up lines high
	initial begin
		testClock = 1'b0;
		modeSelect = 1'b1;
		testDataIn = 1'b1;
		pinALow = 1'b0;
		pinBLow = 1'b0;
	end
	// Inputs move while the clock is low; data out taken just before the rise, as the fall left it
	task automatic frame(input logic [63:0] tms, input logic [63:0] tdi, input int n);
		#1.3;
		for (int i = 0; i < n; i++) begin
			modeSelect = tms[i];
			testDataIn = tdi[i];
			#3;
			tdoSeen[i] = testDataOut;
			oeSeen[i] = testDataOutOe;
			testClock = 1'b1;
			#3 testClock = 1'b0;
		end
		modeSelect = 1'b1;
		testDataIn = 1'b1;
	endtask
	// Event pulls; the disable request is a test aid only, never bus sharing
	task automatic pins(input logic aLow, input logic bLow);
		pinALow = aLow;
		pinBLow = bLow;
	endtask
endmodule
`default_nettype wire

// >>> verif/stp_scan_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module stp_scan_port_checker (
	// Clocks and reset
	input wire logic mclk,
	input wire logic nrst,
	input wire logic testClock,
	// Watched pins
	input wire logic scanReset,
	input wire logic testDataOut,
	input wire logic testDataOutOe,
	input wire logic emulatorEventPinAIn,
	input wire logic emulatorEventBOrOutputDisableIn,
	input wire logic emuIrqA,
	input wire logic emuIrqB,
	input wire logic outputsDisabled,
	input wire logic hostReadyIn,
	input wire logic hostPortReadyOut,
	input wire logic hostPortReadyOutOe
);
	logic tdoRise;
	logic offWanted;
	logic irqA;
	logic irqB;
	// Data out as it stood just before the rising edge
	always_ff @(posedge testClock) tdoRise <= testDataOut;
	// Pin conditions seen by the core
	assign offWanted = !scanReset && emulatorEventPinAIn && !emulatorEventBOrOutputDisableIn;
	assign irqA = scanReset && !emulatorEventPinAIn;
	assign irqB = scanReset && !emulatorEventBOrOutputDisableIn;
	chk_host_float: assert property (
		@(posedge mclk) disable iff (!nrst) offWanted[*4] |-> !hostPortReadyOutOe) else $error("host oe");
	chk_ready_copy: assert property (
		@(posedge mclk) disable iff (!nrst) $past(nrst) |-> hostPortReadyOut == $past(hostReadyIn)) else $error("ready");
	chk_off_enter: assert property (
		@(posedge mclk) disable iff (!nrst) offWanted[*4] |-> outputsDisabled) else $error("off missed");
	chk_off_leave: assert property (
		@(posedge mclk) disable iff (!nrst) (!offWanted)[*4] |-> !outputsDisabled) else $error("off false");
	chk_irq_a: assert property (
		@(posedge mclk) disable iff (!nrst) irqA[*4] |-> emuIrqA) else $error("event a");
	chk_irq_b: assert property (
		@(posedge mclk) disable iff (!nrst) irqB[*4] |-> emuIrqB) else $error("event b");
	chk_tdo_fall: assert property (
		@(negedge testClock) disable iff (!scanReset) testDataOut == tdoRise) else $error("data out moved");
	chk_tdo_float: assert property (
		@(negedge testClock) disable iff (!nrst) !scanReset ##1 !scanReset |-> !testDataOutOe) else $error("driven");
	cov_off: cover property (@(posedge mclk) $rose(outputsDisabled));
	cov_irq: cover property (@(posedge mclk) emuIrqA && emuIrqB);
	cov_shift: cover property (@(negedge testClock) $rose(testDataOutOe));
endmodule
bind stp_scan_port stp_scan_port_checker i_stp_scan_port_checker (.mclk, .nrst, .testClock, .scanReset, .testDataOut,
	.testDataOutOe, .emulatorEventPinAIn, .emulatorEventBOrOutputDisableIn, .emuIrqA, .emuIrqB, .outputsDisabled,
	.hostReadyIn, .hostPortReadyOut, .hostPortReadyOutOe);
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import stp_pkg::*;
	logic        mclk, nrst, scanReset, coreEventA, coreEventB, hostReadyIn, testClock, modeSelect, testDataIn;
	logic        testDataOut, testDataOutOe, pinALow, pinBLow, pinAOut, pinAOe, pinBOut, pinBOe;
	logic        emuIrqA, emuIrqB, scanControl, outputsDisabled, hostPortReadyOut, hostPortReadyOutOe;
	logic [31:0] dout;
	int          numErrors, checkCount;
	// Pins: pull-up, emulator may pull low
	wire pinA = (pinAOe ? pinAOut : 1'b1) & !pinALow;
	wire pinB = (pinBOe ? pinBOut : 1'b1) & !pinBLow;
	stp_scan_port i_stp_scan_port (.mclk, .nrst, .testClock, .scanReset, .modeSelect, .testDataIn, .testDataOut,
		.testDataOutOe, .emulatorEventPinAIn(pinA), .emulatorEventPinAOut(pinAOut), .emulatorEventPinAOe(pinAOe),
		.emulatorEventBOrOutputDisableIn(pinB), .emulatorEventBOrOutputDisableOut(pinBOut),
		.emulatorEventBOrOutputDisableOe(pinBOe), .coreEventA, .coreEventB, .emuIrqA, .emuIrqB, .scanControl,
		.outputsDisabled, .hostReadyIn, .hostPortReadyOut, .hostPortReadyOutOe);
	stp_emu_model i_stp_emu_model (.testClock, .modeSelect, .testDataIn, .testDataOut, .testDataOutOe, .pinALow,
		.pinBLow);
	// Core clock; ready level toggles every cycle
	always #4 mclk = ~mclk;
	always @(posedge mclk) hostReadyIn <= ~hostReadyIn;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checkCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic waitClk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// One scan from idle: n bits in, result in dout, enable window judged
	task automatic scan(input logic ir, input logic [31:0] din, input int n);
		logic [63:0] tms;
		logic [63:0] oe;
		int          p;
		p = ir ? 5 : 4;
		tms = ir ? 64'h6 : 64'h2;
		tms[p+n-1] = 1'b1;
		tms[p+n] = 1'b1;
		i_stp_emu_model.frame(tms, 64'(din) << p, p + n + 2);
		dout = 32'((i_stp_emu_model.tdoSeen >> p) & ((64'h1 << n) - 1));
		oe = (i_stp_emu_model.oeSeen >> (p - 1)) & ((64'h1 << (n + 2)) - 1);
		check(oe, scanReset ? ((64'h1 << n) - 1) << 1 : 64'h0, "enable");
	endtask
	task automatic test_idcode();
		scan(1'b1, 32'hf, 4);
		@(posedge mclk) scanReset <= 1'b1;
		waitClk(5);
		check(scanControl, 1'b1, "scan control");
		scan(1'b0, 32'h0, 32);
		check(dout, ID_VALUE, "identity");
		$display("test_idcode done");
	endtask
	task automatic test_bypass();
		scan(1'b1, 32'hf, 4);
		check(dout, IR_CAPTURE, "ir capture");
		scan(1'b0, 32'ha5, 8);
		check(dout, 32'h4a, "bypass");
		$display("test_bypass done");
	endtask
	task automatic test_emu();
		scan(1'b1, 32'(IR_EMUCTRL), 4);
		scan(1'b0, 32'h5, 4);
		check(dout, 32'ha, "control capture");
		waitClk(5);
		check({pinAOe, pinAOut, emuIrqA}, 3'b101, "pin a event");
		check({pinBOe, pinBOut, emuIrqB}, 3'b101, "pin b drive");
		@(posedge mclk);
		coreEventA <= 1'b1;
		coreEventB <= 1'b1;
		waitClk(5);
		check({pinAOut, emuIrqA}, 2'b10, "core event a");
		check({pinBOut, emuIrqB}, 2'b10, "core event b");
		scan(1'b0, 32'h0, 4);
		check(dout, 32'hf, "driven capture");
		@(posedge mclk);
		coreEventA <= 1'b0;
		coreEventB <= 1'b0;
		waitClk(1);
		i_stp_emu_model.pins(1'b1, 1'b1);
		waitClk(5);
		check({pinAOe, pinBOe, emuIrqA, emuIrqB}, 4'h3, "emulator pulls");
		i_stp_emu_model.pins(1'b0, 1'b0);
		$display("test_emu done");
	endtask
	task automatic test_off();
		@(posedge mclk) scanReset <= 1'b0;
		waitClk(1);
		i_stp_emu_model.pins(1'b0, 1'b1);
		waitClk(5);
		check({outputsDisabled, hostPortReadyOutOe, testDataOutOe, pinAOe, pinBOe, scanControl}, 6'h20,
			"off");
		i_stp_emu_model.pins(1'b1, 1'b1);
		waitClk(5);
		check({outputsDisabled, hostPortReadyOutOe}, 2'b01, "pin a low");
		i_stp_emu_model.pins(1'b0, 1'b0);
		$display("test_off done");
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Cut a hang short
	initial begin
		#50000;
		numErrors++;
		giveVerdict();
	end
	// Main sequence
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		scanReset = 1'b0;
		coreEventA = 1'b0;
		coreEventB = 1'b0;
		hostReadyIn = 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		waitClk(2);
		test_idcode();
		test_bypass();
		test_emu();
		test_off();
		giveVerdict();
	end
endmodule
`default_nettype wire
